// ---- src/ffp_cfg.svh ----
`ifndef FFP_CFG_SVH
`define FFP_CFG_SVH
`define FFP_PC_W 13
`define FFP_INSN_W 16
`define FFP_DATA_W 8
`define FFP_PC_RST 13'h0000
`define FFP_PC_ONE 13'h0001
`define FFP_ACC_RST 8'h00
`define FFP_QPC_RST 4'h8
`define FFP_INSN_NOP 16'h0000
`define FFP_OP_MSB 15
`define FFP_OP_LSB 12
`define FFP_ARG_MSB 7
`define FFP_TGT_MSB 12
`define FFP_LONG_BIT 11
`define FFP_SRC_FAST_INTERNAL_RC_OSC 2'h0
`define FFP_SRC_SLOW_INTERNAL_RC_OSC 2'h1
`define FFP_SRC_LXT 2'h2
`endif

// ---- src/ffp_core.sv ----
// Notes on behaviour
// - Four non-overlapping phases in fixed order
// - One four-phase pass is one cycle
// - PC advances and fetch at phase one
// - Phases two to four decode, execute
// - Fetch next overlaps execute of current
// - PC-loading instructions take extra cycle
// - Branch: fetch target, then transfer
// - Long instructions two cycles, branches too
// - Eight-bit ALU covers instruction operations
// - Data flows through accumulator and ALU
// - Clock source selectable from three oscillators
// - Taken skip (long bit clear) discards prefetch, dummy cycle
// - PC low write jumps in page
`include "ffp_cfg.svh"
module ffp_core
	import ffp_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Oscillator clocks (each rising edge is one phase tick) and select
	input wire logic fast_internal_rc_osc,
	input wire logic slow_internal_rc_osc,
	input wire logic slow_crystal_osc,
	input wire logic [1:0] osc_sel,
	// Program memory
	output ffp_fetch_t fetch_q,
	input wire logic [`FFP_INSN_W-1:0] insn_rdata,
	// Data memory operand
	input wire logic [`FFP_DATA_W-1:0] mem_rdata,
	// Status
	output ffp_phases_t quarter_phase_clocks_q,
	output logic [`FFP_PC_W-1:0] pc_q,
	output logic [`FFP_DATA_W-1:0] acc_q,
	output logic carry_q,
	output logic zero_q,
	output logic dummy_q
);
	// ----------------------------------------
	// Clock source and phase generator
	// ----------------------------------------
	logic [2:0] osc_s1_q, osc_s2_q, osc_s3_q;
	logic [2:0] osc_s1_d, osc_s2_d, osc_s3_d;
	logic tick;
	ffp_phase_t phase_q, phase_d;
	ffp_phases_t qpc_d;
	always_comb
	begin
		osc_s1_d = {slow_crystal_osc, slow_internal_rc_osc, fast_internal_rc_osc};
		osc_s2_d = osc_s1_q;
		osc_s3_d = osc_s2_q;
		case (osc_sel)
			`FFP_SRC_FAST_INTERNAL_RC_OSC: tick = osc_s2_q[0] & ~osc_s3_q[0];
			`FFP_SRC_SLOW_INTERNAL_RC_OSC: tick = osc_s2_q[1] & ~osc_s3_q[1];
			`FFP_SRC_LXT: tick = osc_s2_q[2] & ~osc_s3_q[2];
			default: tick = osc_s2_q[0] & ~osc_s3_q[0];
		endcase
		phase_d = phase_q;
		if (tick)
		begin
			case (phase_q)
				PH_T1: phase_d = PH_T2;
				PH_T2: phase_d = PH_T3;
				PH_T3: phase_d = PH_T4;
				PH_T4: phase_d = PH_T1;
				default: phase_d = PH_T1;
			endcase
		end
		qpc_d.t1 = (phase_d == PH_T1);
		qpc_d.t2 = (phase_d == PH_T2);
		qpc_d.t3 = (phase_d == PH_T3);
		qpc_d.t4 = (phase_d == PH_T4);
	end
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_s1_q <= 3'h0;
			osc_s2_q <= 3'h0;
			osc_s3_q <= 3'h0;
			phase_q <= PH_T1;
			quarter_phase_clocks_q <= `FFP_QPC_RST;
		end
		else
		begin
			osc_s1_q <= osc_s1_d;
			osc_s2_q <= osc_s2_d;
			osc_s3_q <= osc_s3_d;
			phase_q <= phase_d;
			quarter_phase_clocks_q <= qpc_d;
		end
	end
	// ----------------------------------------
	// Fetch, decode and execute
	// ----------------------------------------
	logic start_t1, end_t1, exec_t4;
	logic [`FFP_INSN_W-1:0] ir_q, ir_d;
	logic ir_vld_q, ir_vld_d;
	logic [`FFP_INSN_W-1:0] pf_q, pf_d;
	logic pf_vld_q, pf_vld_d;
	logic redirect_q, skip_q;
	logic [1:0] stall_q, stall_d;
	logic [`FFP_PC_W-1:0] pc_d;
	logic [`FFP_DATA_W-1:0] acc_d, arg;
	logic [`FFP_DATA_W:0] sum;
	logic carry_d, zero_d, dummy_d;
	ffp_fetch_t fetch_d;
	ffp_op_t op;
	logic redirect, skip;
	logic [`FFP_PC_W-1:0] target;
	always_comb
	begin
		start_t1 = tick && (phase_q == PH_T4);
		end_t1 = tick && (phase_q == PH_T1);
		exec_t4 = tick && (phase_q == PH_T3);
		op = ffp_op_t'(ir_q[`FFP_OP_MSB:`FFP_OP_LSB]);
		arg = ir_q[`FFP_ARG_MSB:0] ^ mem_rdata;
		target = ir_q[`FFP_TGT_MSB:0];
		ir_d = ir_q;
		ir_vld_d = ir_vld_q;
		pf_d = pf_q;
		pf_vld_d = pf_vld_q;
		stall_d = stall_q;
		pc_d = pc_q;
		acc_d = acc_q;
		carry_d = carry_q;
		zero_d = zero_q;
		dummy_d = dummy_q;
		fetch_d = fetch_q;
		sum = {1'b0, acc_q};
		redirect = 1'b0;
		skip = 1'b0;
		if (exec_t4 && ir_vld_q && !dummy_q && stall_q == 2'h0)
		begin
			case (op)
				OP_ADD: sum = {1'b0, acc_q} + {1'b0, arg};
				OP_SUB: sum = {1'b0, acc_q} - {1'b0, arg};
				OP_AND: sum = {1'b0, acc_q & arg};
				OP_OR: sum = {1'b0, acc_q | arg};
				OP_XOR: sum = {1'b0, acc_q ^ arg};
				OP_RR: sum = {acc_q[0], carry_q, acc_q[`FFP_DATA_W-1:1]};
				OP_RL: sum = {acc_q, carry_q};
				OP_INC: sum = {1'b0, acc_q} + 9'h001;
				OP_DEC: sum = {1'b0, acc_q} - 9'h001;
				OP_MOV: sum = {1'b0, arg};
				OP_CPL: sum = {1'b0, ~acc_q};
				OP_SZ: skip = (arg == `FFP_ACC_RST);
				OP_PCL: redirect = 1'b1;
				OP_JMP, OP_CALL: redirect = 1'b1;
				default: sum = {1'b0, acc_q};
			endcase
			if (op inside {OP_ADD, OP_SUB, OP_RR, OP_RL, OP_INC, OP_DEC})
				carry_d = sum[`FFP_DATA_W];
			acc_d = sum[`FFP_DATA_W-1:0];
			zero_d = (sum[`FFP_DATA_W-1:0] == `FFP_ACC_RST);
			if (op == OP_PCL)
				pc_d = {pc_q[`FFP_PC_W-1:`FFP_DATA_W], ir_q[`FFP_ARG_MSB:0]};
			else if (redirect)
				pc_d = target;
			if (ir_q[`FFP_LONG_BIT] && !redirect)
				stall_d = 2'h1;
		end
		if (start_t1)
		begin
			dummy_d = redirect_q || skip_q;
			if (stall_q != 2'h0)
			begin
				// Idle cycle, prefetched word kept for later
				stall_d = stall_q - 2'h1;
				ir_vld_d = 1'b0;
			end
			else
			begin
				ir_d = pf_q;
				ir_vld_d = pf_vld_q;
				fetch_d.addr = pc_q;
				fetch_d.req = 1'b1;
				pc_d = pc_q + `FFP_PC_ONE;
			end
		end
		if (end_t1 && fetch_q.req)
		begin
			pf_d = insn_rdata;
			pf_vld_d = 1'b1;
			fetch_d.req = 1'b0;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ir_q <= `FFP_INSN_NOP;
			ir_vld_q <= 1'b0;
			pf_q <= `FFP_INSN_NOP;
			pf_vld_q <= 1'b0;
			stall_q <= 2'h0;
			pc_q <= `FFP_PC_RST;
			acc_q <= `FFP_ACC_RST;
			carry_q <= 1'b0;
			zero_q <= 1'b0;
			dummy_q <= 1'b0;
			fetch_q <= '0;
			redirect_q <= 1'b0;
			skip_q <= 1'b0;
		end
		else
		begin
			ir_q <= ir_d;
			ir_vld_q <= ir_vld_d;
			pf_q <= pf_d;
			pf_vld_q <= pf_vld_d;
			stall_q <= stall_d;
			pc_q <= pc_d;
			acc_q <= acc_d;
			carry_q <= carry_d;
			zero_q <= zero_d;
			dummy_q <= dummy_d;
			fetch_q <= fetch_d;
			if (exec_t4)
			begin
				redirect_q <= redirect;
				skip_q <= skip;
			end
			else if (start_t1 && stall_q == 2'h0)
			begin
				redirect_q <= 1'b0;
				skip_q <= 1'b0;
			end
		end
	end
endmodule

// ---- src/ffp_pkg.sv ----
package ffp_pkg;
	typedef enum logic [1:0]
	{
		PH_T1 = 2'b00,
		PH_T2 = 2'b01,
		PH_T3 = 2'b10,
		PH_T4 = 2'b11
	} ffp_phase_t;
	typedef enum logic [3:0]
	{
		OP_NOP = 4'h0,
		OP_ADD = 4'h1,
		OP_SUB = 4'h2,
		OP_AND = 4'h3,
		OP_OR = 4'h4,
		OP_XOR = 4'h5,
		OP_RR = 4'h6,
		OP_RL = 4'h7,
		OP_INC = 4'h8,
		OP_DEC = 4'h9,
		OP_MOV = 4'hA,
		OP_SZ = 4'hB,
		OP_PCL = 4'hC,
		OP_JMP = 4'hD,
		OP_CALL = 4'hE,
		OP_CPL = 4'hF
	} ffp_op_t;
	typedef struct packed
	{
		logic t1;
		logic t2;
		logic t3;
		logic t4;
	} ffp_phases_t;
	typedef struct packed
	{
		logic [12:0] addr;
		logic req;
	} ffp_fetch_t;
endpackage

// ---- tb/ffp_mem.sv ----
module ffp_mem
	import ffp_pkg::*;
(
	// Fetch port
	input wire logic sys_clk,
	input ffp_fetch_t fetch_q,
	output logic [15:0] insn_rdata
);
	logic [15:0] rom [256];
	// Released bus toggles each half cycle
	always_comb insn_rdata = fetch_q.req ? rom[fetch_q.addr[7:0]] : {16{sys_clk}} ^ 16'hA5A5;
	initial
	begin
		foreach (rom[i])
			rom[i] = 16'h0000;
		rom[0] = 16'hA03C;
		rom[1] = 16'h1005;
		rom[2] = 16'h2001;
		rom[3] = 16'h30F0;
		rom[4] = 16'h400F;
		rom[5] = 16'h50FF;
		rom[7] = 16'hD020;
		rom[8] = 16'hA011;
		rom[32] = 16'hA077;
		rom[33] = 16'hB000;
		rom[34] = 16'hA011;
		rom[35] = 16'hA099;
		rom[36] = 16'hC030;
		rom[48] = 16'hA05A;
		rom[49] = 16'h8800;
		rom[50] = 16'hA0F0;
		rom[51] = 16'h8000;
	end
endmodule

// ---- tb/ffp_props.sv ----
module ffp_props
	import ffp_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Core outputs
	input ffp_fetch_t fetch_q,
	input ffp_phases_t quarter_phase_clocks_q,
	input wire logic [12:0] pc_q,
	input wire logic [7:0] acc_q,
	input wire logic carry_q,
	input wire logic zero_q,
	input wire logic dummy_q
);
	// ----
	// Checks
	// ----
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic [3:0] ph = quarter_phase_clocks_q;
	one_hot_a: assert property ($onehot(ph))
		else $error("phase not one-hot");
	phase_order_a: assert property ($changed(ph) |-> $past(ph) == {ph[2:0], ph[3]})
		else $error("phase order broken");
	fetch_phase_a: assert property (fetch_q.req |-> ph[3])
		else $error("fetch outside phase one");
	pc_step_a: assert property ($rose(fetch_q.req) |-> pc_q == fetch_q.addr + 13'h0001)
		else $error("pc not advanced at fetch");
	req_span_a: assert property ($fell(fetch_q.req) |-> $fell(ph[3]))
		else $error("fetch ends off phase edge");
	addr_hold_a: assert property (fetch_q.req && $past(fetch_q.req) |-> $stable(fetch_q.addr))
		else $error("fetch address moved");
	exec_edge_a: assert property ($changed({acc_q, carry_q, zero_q}) |-> ph[0])
		else $error("result outside phase four");
	reset_state_a: assert property (!$past(rst_n) |-> ph == 4'h8 && !fetch_q.req)
		else $error("bad state after reset");
	dummy_hold_a: assert property (dummy_q && $past(dummy_q) |-> $stable(acc_q))
		else $error("dummy cycle executed");
	cover property ($rose(dummy_q));
	cover property ($rose(fetch_q.req));
	cover property ($changed(acc_q));
endmodule
bind ffp_core ffp_props chk (.sys_clk, .rst_n, .fetch_q, .quarter_phase_clocks_q, .pc_q,
	.acc_q, .carry_q, .zero_q, .dummy_q);

// ---- tb/four_phase_fetch_execute_pipeline_bench.sv ----
module four_phase_fetch_execute_pipeline_bench
	import ffp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk;
	logic rst_n;
	logic [2:0] osc_q = 3'h0;
	logic [1:0] osc_sel;
	logic [7:0] mem_rdata;
	logic [15:0] insn_rdata;
	ffp_fetch_t fetch_q;
	ffp_phases_t qpc;
	logic [12:0] pc_q;
	logic [7:0] acc_q;
	logic carry_q;
	logic zero_q;
	logic dummy_q;
	wire logic [10:0] outs = {carry_q, zero_q, dummy_q, acc_q};
	int bad_count = 0;
	int tests_run = 0;
	time t0;
	// Operand for this cycle's execute, then {carry, zero, dummy, acc}
	logic [18:0] rows [23] = '{19'h00000, 19'h00000, 19'h00000, 19'h0003C, 19'h00041,
		19'h00040, 19'h00040, 19'h0004F, 19'h000B0, 19'h000B0, 19'h001B0, 19'h000B0,
		19'h00077, 19'h00177, 19'h00077, 19'h00099, 19'h00199, 19'h00099, 19'h0005A,
		19'h0005B, 19'h0785B, 19'h000FF, 19'h00600};
	ffp_core uut (.sys_clk, .rst_n, .fast_internal_rc_osc(osc_q[0]),
		.slow_internal_rc_osc(osc_q[1]), .slow_crystal_osc(osc_q[2]), .osc_sel, .fetch_q,
		.insn_rdata, .mem_rdata, .quarter_phase_clocks_q(qpc), .pc_q, .acc_q, .carry_q,
		.zero_q, .dummy_q);
	ffp_mem mem (.sys_clk, .fetch_q, .insn_rdata);
	// ----
	// Clock and tasks
	// ----
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) osc_q <= osc_q + 3'h1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task end_sim;
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		end_sim;
	end
	// ----
	// Tests
	// ----
	initial
	begin
		rst_n = 1'b0;
		osc_sel = 2'h0;
		mem_rdata = 8'h00;
		repeat (16) @(negedge sys_clk);
		chk(32'({qpc, fetch_q.req, acc_q, pc_q}), 32'h0200_0000);
		rst_n = 1'b1;
		foreach (rows[i])
		begin
			@(posedge qpc.t2);
			@(negedge sys_clk);
			chk(32'(outs), 32'(rows[i][10:0]));
			mem_rdata = rows[i][18:11];
		end
		for (int s = 0; s < 4; s++)
		begin
			@(negedge sys_clk);
			osc_sel = 2'(s);
			repeat (2) @(posedge qpc.t1);
			t0 = $time;
			@(posedge qpc.t1);
			chk(32'(($time - t0) / 4), s == 3 ? 32'h8 : 32'h8 << s);
		end
		@(negedge sys_clk);
		rst_n = 1'b0;
		@(negedge sys_clk);
		chk(32'({qpc, fetch_q.req, acc_q, pc_q}), 32'h0200_0000);
		rst_n = 1'b1;
		@(posedge qpc.t2);
		@(negedge sys_clk);
		chk(32'({qpc, fetch_q.req, dummy_q, acc_q, pc_q}), 32'h0200_0000);
		end_sim;
	end
endmodule
